// ==== mbtcp_defines.svh ====
// Modbus-TCP client constants: header layout, function codes, sizes.
// Assumes inclusion by the package and by the client modules.
`ifndef MBTCP_DEFINES_SVH
`define MBTCP_DEFINES_SVH
`define MB_HDR_BYTES       4'd7
`define MB_PROTO_ID        16'h0000
`define MB_UNIT_MAX        8'hf7
`define MB_FC_RD_RELAY     8'h01
`define MB_FC_RD_INPUT     8'h02
`define MB_FC_RD_REGS      8'h03
`define MB_FC_FORCE_RELAY  8'h05
`define MB_FC_WR_REGS      8'h10
`define MB_RELAY_ON        16'hff00
`define MB_RELAY_OFF       16'h0000
`define MB_FIFO_DEPTH      16
`define MB_RSP_TIMEOUT_US  1000
`define MB_CLK_MHZ         100
`define MB_RSP_TIMEOUT_CYC (`MB_RSP_TIMEOUT_US * `MB_CLK_MHZ)
`endif

// ==== mbtcp_pkg.sv ====
// Types shared by the Modbus-TCP client modules.
// Assumes the defines header is on the include path.
`include "mbtcp_defines.svh"
package mbtcp_pkg;
   typedef enum logic [3:0] {
      st_idle   = 4'b0000,
      st_hdr    = 4'b0001,
      st_func   = 4'b0010,
      st_addr   = 4'b0011,
      st_qty    = 4'b0100,
      st_bcnt   = 4'b0101,
      st_wdata  = 4'b0110,
      st_rsp    = 4'b0111,
      st_done   = 4'b1000
   } client_state_t;
endpackage

// ==== mbtcp_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides; read data is registered.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
module mbtcp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             reset_n_i,
   // Fill side
   input  wire logic             in_valid_i,
   output      logic             in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output      logic             out_valid_o,
   input  wire logic             out_ready_i,
   output      logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_depth
      $error("fifo depth must be a power of two, at least 2");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic             out_valid;
   logic [WIDTH-1:0] out_data;
   logic             full;
   logic [AW+1:0]    level;
   logic             stored;
   logic             push;
   logic             pop;
   // Output register is one of the DEPTH words, so the fill side sees exactly DEPTH
   assign level       = {1'b0, wr_ptr - rd_ptr} + (AW+2)'(out_valid);
   assign full        = (level >= (AW+2)'(DEPTH));
   assign stored      = (wr_ptr != rd_ptr);
   assign in_ready_o  = !full;
   assign push        = in_valid_i && !full;
   assign pop         = stored && (!out_valid || out_ready_i);
   assign out_valid_o = out_valid;
   assign out_data_o  = out_data;
   always_ff @(posedge ref_clk_i) begin
      if (push)
         mem[wr_ptr[AW-1:0]] <= in_data_i;
   end
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         out_valid <= 1'b0;
         out_data  <= '0;
      end else begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop) begin
            rd_ptr    <= rd_ptr + 1'b1;
            out_data  <= mem[rd_ptr[AW-1:0]];
            out_valid <= 1'b1;
         end else if (out_ready_i) begin
            out_valid <= 1'b0;
         end
      end
   end
endmodule

// ==== mbtcp_client.sv ====
// Modbus-TCP client: builds request frames byte by byte onto the TCP link
// and checks the response header. Write data for function 16 is buffered.
// Assumes a TCP stack below that carries bytes over an open connection.
`timescale 1ns/1ns
`include "mbtcp_defines.svh"
// Notes on behaviour
// - Frame is seven header bytes, one function byte, then data bytes.
// - Bytes 1-2 carry transaction id; bytes 3-4 protocol id, always zero.
// - Length field counts all bytes after itself.
// - Last header byte is unit id, valid 0 to 247.
// - Function code is eight bits, legal values 1 to 255; client takes only 1, 2, 3, 5 and 16 and refuses the rest.
// - Data field is bytes of any value 00 to ff.
// - Register read data holds start address then register count.
// - Multiple write data holds start address, count, byte count, then values.
// - Client waits for an open TCP connection (link_up_i) before taking any request.
// - Two-byte fields go high byte first.
module mbtcp_client
   import mbtcp_pkg::*;
#(
   parameter int          FIFO_DEPTH  = `MB_FIFO_DEPTH,
   parameter int unsigned TIMEOUT_CYC = `MB_RSP_TIMEOUT_CYC
) (
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        reset_n_i,
   // Request command
   input  wire logic        req_valid_i,
   output      logic        req_ready_o,
   input  wire logic [7:0]  req_func_i,
   input  wire logic [7:0]  req_unit_i,
   input  wire logic [15:0] req_addr_i,
   input  wire logic [15:0] req_qty_i,
   // Register values for function 16
   input  wire logic        wdata_valid_i,
   output      logic        wdata_ready_o,
   input  wire logic [15:0] wdata_i,
   // TCP link
   input  wire logic        link_up_i,
   output      logic        tx_valid_o,
   input  wire logic        tx_ready_i,
   output      logic [7:0]  tx_data_o,
   input  wire logic        rx_valid_i,
   output      logic        rx_ready_o,
   input  wire logic [7:0]  rx_data_i,
   // Completion
   output      logic        done_o,
   output      logic        rsp_ok_o,
   output      logic        rsp_err_o,
   output      logic        bad_req_o
);
   if (TIMEOUT_CYC < 1 || FIFO_DEPTH < 2) begin : g_bad_param
      $error("bad client parameters");
   end
   // ********************************
   // State
   // ********************************
   typedef struct packed {
      client_state_t st;
      logic [15:0]   tid;
      logic [7:0]    func;
      logic [7:0]    unit;
      logic [15:0]   addr;
      logic [15:0]   qty;
      logic [15:0]   len;
      logic [15:0]   wcnt;
      logic [3:0]    idx;
      logic [15:0]   rx_cnt;
      logic [7:0]    rx_b4;
      logic          mismatch;
      logic [31:0]   timer;
      logic          done;
      logic          ok;
      logic          err;
      logic          bad;
      logic [7:0]    tx_byte;
      logic          tx_vld;
   } client_t;
   client_t r;
   client_t next_r;
   logic        f_valid;
   logic        f_ready;
   logic [15:0] f_data;
   mbtcp_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) wbuf (
      .ref_clk_i   (ref_clk_i),
      .reset_n_i   (reset_n_i),
      .in_valid_i  (wdata_valid_i),
      .in_ready_o  (wdata_ready_o),
      .in_data_i   (wdata_i),
      .out_valid_o (f_valid),
      .out_ready_i (f_ready),
      .out_data_o  (f_data)
   );
   // Length field: unit + function + data bytes
   function automatic logic [15:0] frame_len(input logic [7:0] fc, input logic [15:0] q);
      if (fc == `MB_FC_WR_REGS)
         frame_len = 16'(7 + 2 * q);
      else
         frame_len = 16'd6;
   endfunction
   function automatic logic supported(input logic [7:0] fc);
      supported = (fc == `MB_FC_RD_RELAY) || (fc == `MB_FC_RD_INPUT) ||
                  (fc == `MB_FC_RD_REGS) || (fc == `MB_FC_FORCE_RELAY) ||
                  (fc == `MB_FC_WR_REGS);
   endfunction
   // ********************************
   // Sequencer
   // ********************************
   logic tx_adv;
   assign tx_adv      = r.tx_vld && tx_ready_i;
   assign req_ready_o = (r.st == st_idle) && link_up_i;
   assign tx_valid_o  = r.tx_vld;
   assign tx_data_o   = r.tx_byte;
   // Answer bytes are taken only once the last request byte has gone out
   assign rx_ready_o  = (r.st == st_rsp) && !r.tx_vld;
   assign f_ready     = (r.st == st_wdata) && !r.tx_vld && r.idx[0] == 1'b0;
   assign done_o      = r.done;
   assign rsp_ok_o    = r.ok;
   assign rsp_err_o   = r.err;
   assign bad_req_o   = r.bad;
   always_comb begin
      next_r      = r;
      next_r.done = 1'b0;
      if (tx_adv)
         next_r.tx_vld = 1'b0;
      unique case (r.st)
         st_idle: begin
            if (req_valid_i && link_up_i) begin
               // Unit id above 247, code 0 or unsupported code never go out
               if (req_unit_i > `MB_UNIT_MAX || req_func_i == 8'h00 ||
                   !supported(req_func_i) || (req_func_i == `MB_FC_FORCE_RELAY &&
                   req_qty_i != `MB_RELAY_ON && req_qty_i != `MB_RELAY_OFF)) begin
                  next_r.bad  = 1'b1;
                  next_r.done = 1'b1;
               end else begin
                  next_r.bad  = 1'b0;
                  next_r.ok   = 1'b0;
                  next_r.err  = 1'b0;
                  next_r.func = req_func_i;
                  next_r.unit = req_unit_i;
                  next_r.addr = req_addr_i;
                  next_r.qty  = req_qty_i;
                  next_r.len  = frame_len(req_func_i, req_qty_i);
                  next_r.idx  = 4'd0;
                  next_r.st   = st_hdr;
               end
            end
         end
         st_hdr: begin
            if (!r.tx_vld || tx_adv) begin
               next_r.tx_vld = 1'b1;
               unique case (r.idx)
                  4'd0:    next_r.tx_byte = r.tid[15:8];
                  4'd1:    next_r.tx_byte = r.tid[7:0];
                  4'd2:    next_r.tx_byte = 8'(`MB_PROTO_ID >> 8);
                  4'd3:    next_r.tx_byte = 8'(`MB_PROTO_ID);
                  4'd4:    next_r.tx_byte = r.len[15:8];
                  4'd5:    next_r.tx_byte = r.len[7:0];
                  default: next_r.tx_byte = r.unit;
               endcase
               next_r.idx = r.idx + 4'd1;
               if (r.idx == `MB_HDR_BYTES - 4'd1) begin
                  next_r.st = st_func;
               end
            end
         end
         st_func: begin
            if (tx_adv) begin
               next_r.tx_vld  = 1'b1;
               next_r.tx_byte = r.func;
               next_r.idx     = 4'd0;
               next_r.st      = st_addr;
            end
         end
         st_addr, st_qty: begin
            // Address then quantity (or force value), each high byte first
            if (tx_adv) begin
               next_r.tx_vld  = 1'b1;
               next_r.tx_byte = (r.st == st_addr) ?
                  (r.idx[0] ? r.addr[7:0] : r.addr[15:8]) :
                  (r.idx[0] ? r.qty[7:0] : r.qty[15:8]);
               next_r.idx = r.idx + 4'd1;
               if (r.idx[0]) begin
                  next_r.idx = 4'd0;
                  if (r.st == st_addr)
                     next_r.st = st_qty;
                  else
                     next_r.st = (r.func == `MB_FC_WR_REGS) ? st_bcnt : st_rsp;
               end
            end
         end
         st_bcnt: begin
            if (tx_adv) begin
               next_r.tx_vld  = 1'b1;
               next_r.tx_byte = 8'(r.qty << 1);
               next_r.wcnt    = r.qty;
               next_r.st      = (r.qty == 16'd0) ? st_rsp : st_wdata;
            end
         end
         st_wdata: begin
            // Stalls on an empty buffer; low byte held in addr for second beat
            if (f_valid && f_ready) begin
               next_r.tx_vld  = 1'b1;
               next_r.tx_byte = f_data[15:8];
               next_r.addr    = f_data;
               next_r.idx     = 4'd1;
            end else if (r.idx[0] && tx_adv) begin
               next_r.tx_vld  = 1'b1;
               next_r.tx_byte = r.addr[7:0];
               next_r.idx     = 4'd0;
               next_r.wcnt    = r.wcnt - 16'd1;
               if (r.wcnt == 16'd1)
                  next_r.st = st_rsp;
            end
         end
         st_rsp: begin
            if (r.rx_cnt == 16'd0 && !r.tx_vld)
               next_r.timer = r.timer + 32'd1;
            if (rx_valid_i && rx_ready_o) begin
               next_r.rx_cnt = r.rx_cnt + 16'd1;
               unique case (r.rx_cnt)
                  16'd0:   next_r.mismatch = (rx_data_i != r.tid[15:8]);
                  16'd1:   next_r.mismatch = r.mismatch | (rx_data_i != r.tid[7:0]);
                  16'd2,
                  16'd3:   next_r.mismatch = r.mismatch | (rx_data_i != 8'h00);
                  16'd4:   next_r.rx_b4 = rx_data_i;
                  16'd5:   next_r.len = {r.rx_b4, rx_data_i};
                  16'd6:   next_r.mismatch = r.mismatch | (rx_data_i != r.unit);
                  // Whole byte compared, so an exception answer is never taken as good
                  16'd7:   next_r.mismatch = r.mismatch | (rx_data_i != r.func);
                  default: next_r.mismatch = r.mismatch;
               endcase
               // Frame ends once the length field's byte count has passed
               if (r.rx_cnt >= 16'd6 && r.rx_cnt + 16'd1 >= r.len + 16'd6) begin
                  next_r.st = st_done;
               end
            end else if (r.timer >= TIMEOUT_CYC) begin
               next_r.mismatch = 1'b1;
               next_r.st       = st_done;
            end
         end
         st_done: begin
            next_r.done   = 1'b1;
            next_r.ok     = !r.mismatch;
            next_r.err    = r.mismatch;
            next_r.tid    = r.tid + 16'd1;
            next_r.rx_cnt = 16'd0;
            next_r.timer  = 32'd0;
            next_r.mismatch = 1'b0;
            next_r.st     = st_idle;
         end
         default: next_r.st = st_idle;
      endcase
   end
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         r <= '{st: st_idle, default: '0};
      else
         r <= next_r;
   end
endmodule

// ==== mbtcp_client_checker.sv ====
// Port assertions for the Modbus-TCP client.
// Assumes one clock domain and the client's port names.
`timescale 1ns/1ns
module mbtcp_client_checker (
   // Client ports, watched only
   input wire logic        ref_clk_i,
   input wire logic        reset_n_i,
   input wire logic        req_valid_i,
   input wire logic        req_ready_o,
   input wire logic [7:0]  req_func_i,
   input wire logic [7:0]  req_unit_i,
   input wire logic [15:0] req_qty_i,
   input wire logic        link_up_i,
   input wire logic        tx_valid_o,
   input wire logic        tx_ready_i,
   input wire logic [7:0]  tx_data_o,
   input wire logic        rx_ready_o,
   input wire logic        done_o,
   input wire logic        rsp_ok_o,
   input wire logic        rsp_err_o,
   input wire logic        bad_req_o
);
   logic take;
   logic bad_cmd;
   assign take = req_valid_i && req_ready_o;
   assign bad_cmd = req_unit_i > 8'hf7 ||
                    !(req_func_i inside {8'h01, 8'h02, 8'h03, 8'h05, 8'h10}) ||
                    (req_func_i == 8'h05 && req_qty_i != 16'hff00 && req_qty_i != 16'h0000);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   property p_link; req_ready_o |-> link_up_i; endproperty
   a_link: assert property (p_link) else $error("ready without link");
   property p_accept; take && !bad_cmd |=> !bad_req_o && !done_o ##1 tx_valid_o; endproperty
   a_accept: assert property (p_accept) else $error("good request not sent");
   property p_refuse; take && bad_cmd |=> done_o && bad_req_o && !tx_valid_o; endproperty
   a_refuse: assert property (p_refuse) else $error("bad request not refused");
   property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o); endproperty
   a_hold: assert property (p_hold) else $error("tx byte dropped");
   property p_pulse; done_o |=> !done_o; endproperty
   a_pulse: assert property (p_pulse) else $error("done too long");
   property p_busy; tx_valid_o || rx_ready_o |-> !req_ready_o; endproperty
   a_busy: assert property (p_busy) else $error("second request open");
   property p_order; rx_ready_o |-> !tx_valid_o; endproperty
   a_order: assert property (p_order) else $error("answer before frame end");
   property p_keep;
      !$past(take) && !$past(take, 2) && !done_o |->
         $stable(rsp_ok_o) && $stable(rsp_err_o) && $stable(bad_req_o);
   endproperty
   a_keep: assert property (p_keep) else $error("status moved");
endmodule
bind mbtcp_client mbtcp_client_checker mbtcp_client_checker_i (
   .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i),
   .req_ready_o(req_ready_o), .req_func_i(req_func_i), .req_unit_i(req_unit_i),
   .req_qty_i(req_qty_i), .link_up_i(link_up_i), .tx_valid_o(tx_valid_o),
   .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o), .rx_ready_o(rx_ready_o),
   .done_o(done_o), .rsp_ok_o(rsp_ok_o), .rsp_err_o(rsp_err_o), .bad_req_o(bad_req_o));

// ==== mbtcp_server_model.sv ====
// Behavioural Modbus-TCP server on the client's byte link.
// Assumes whole request frames; stall, bad_tid and mute are test modes.
`timescale 1ns/1ns
module mbtcp_server_model (
   // Clock, reset and modes
   input  wire logic       ref_clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       stall_i,
   input  wire logic       bad_tid_i,
   input  wire logic       mute_i,
   // Request bytes
   input  wire logic       tx_valid_i,
   output      logic       tx_ready_o,
   input  wire logic [7:0] tx_data_i,
   // Response bytes
   output      logic       rx_valid_o,
   input  wire logic       rx_ready_i,
   output      logic [7:0] rx_data_o
);
   logic [7:0]  buf_q[$], frame[$], rsp[$];
   logic [15:0] regs[256];
   logic [7:0]  relays = 8'h00;
   logic [7:0]  inputs = 8'h5a;
   initial begin
      tx_ready_o = 1'b0;
      rx_valid_o = 1'b0;
      rx_data_o = 8'h00;
      foreach (regs[i]) regs[i] = 16'(i);
   end
   task automatic serve;
      logic [15:0] a, q, len;
      logic [7:0] d[$];
      frame = buf_q;
      buf_q = {};
      a = {frame[8], frame[9]};
      q = {frame[10], frame[11]};
      case (frame[7])
         8'h01, 8'h02: d = {8'h01, (frame[7] == 8'h01 ? relays : inputs) >> a[2:0]};
         8'h03: begin
            d = {8'(q << 1)};
            for (int i = 0; i < q; i++) d = {d, regs[8'(a + i)][15:8], regs[8'(a + i)][7:0]};
         end
         8'h05: begin
            if (q == 16'hff00 || q == 16'h0000) relays[a[2:0]] = q[15];
            d = frame[8:11];
         end
         8'h10: begin
            for (int i = 0; i < q; i++) regs[8'(a + i)] = {frame[13 + 2 * i], frame[14 + 2 * i]};
            d = frame[8:11];
         end
         default: d = {};
      endcase
      len = 16'(d.size() + 2);
      if ({frame[2], frame[3]} == 16'h0000 && !mute_i)
         rsp = {frame[0], frame[1] ^ {7'h00, bad_tid_i}, 8'h00, 8'h00, len[15:8], len[7:0],
                frame[6], frame[7], d};
   endtask
   // Stalling halves the byte rate so the client must hold its byte
   always @(posedge ref_clk_i) begin
      if (!reset_n_i) buf_q = {};
      else if (tx_valid_i && tx_ready_o) begin
         buf_q.push_back(tx_data_i);
         if (buf_q.size() >= 6 && buf_q.size() == 6 + int'({buf_q[4], buf_q[5]})) serve();
      end
      #1 tx_ready_o = reset_n_i & (~stall_i | ~tx_ready_o);
   end
   // Idle data is the inverse of the last byte, never a stale copy
   always begin
      @(posedge ref_clk_i);
      if (rsp.size() > 0 && reset_n_i) begin
         if (stall_i) repeat (3) @(posedge ref_clk_i);
         #1 rx_valid_o = 1'b1;
         rx_data_o = rsp.pop_front();
         do @(posedge ref_clk_i); while (!rx_ready_i);
         #1 rx_valid_o = 1'b0;
         rx_data_o = ~rx_data_o;
      end
   end
endmodule

// ==== mbtcp_client_test.sv ====
// Self-checking bench for the Modbus-TCP client.
// Assumes the server model on the link and a shortened timeout.
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module mbtcp_client_test;
   logic ref_clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, link_up = 1'b0;
   logic wdata_valid = 1'b0, stall = 1'b0, bad_tid = 1'b0, mute = 1'b0;
   logic [7:0] req_func = 8'h01, req_unit = 8'h01, tx_data, rx_data;
   logic [15:0] req_addr = 16'h0000, req_qty = 16'h0001, wdata = 16'h0000, tid = 16'h0000;
   logic req_ready, wdata_ready, tx_valid, tx_ready, rx_valid, rx_ready;
   logic done, rsp_ok, rsp_err, bad_req;
   int err_count = 0, check_count = 0;
   mbtcp_client #(.TIMEOUT_CYC(200)) mbtcp_client_i (
      .ref_clk_i(ref_clk), .reset_n_i(reset_n), .req_valid_i(req_valid),
      .req_ready_o(req_ready), .req_func_i(req_func), .req_unit_i(req_unit),
      .req_addr_i(req_addr), .req_qty_i(req_qty), .wdata_valid_i(wdata_valid),
      .wdata_ready_o(wdata_ready), .wdata_i(wdata), .link_up_i(link_up),
      .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .tx_data_o(tx_data),
      .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .rx_data_i(rx_data), .done_o(done),
      .rsp_ok_o(rsp_ok), .rsp_err_o(rsp_err), .bad_req_o(bad_req));
   mbtcp_server_model mbtcp_server_model_i (
      .ref_clk_i(ref_clk), .reset_n_i(reset_n), .stall_i(stall), .bad_tid_i(bad_tid),
      .mute_i(mute), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .tx_data_i(tx_data),
      .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .rx_data_o(rx_data));
   initial forever #5 ref_clk = ~ref_clk;
   task automatic finish_test;
      $display("Checks %0d, errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cycle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic do_req(input logic [7:0] f, u, input logic [15:0] a, q);
      int n;
      req_func = f;
      req_unit = u;
      req_addr = a;
      req_qty = q;
      req_valid = 1'b1;
      for (n = 0; n < 50 && req_ready !== 1'b1; n++) cycle(1);
      cycle(1);
      req_valid = 1'b0;
      for (n = 0; n < 2000 && done !== 1'b1; n++) cycle(1);
      `CHK(done, 1'b1)
      cycle(1);
   endtask
   task automatic chk_hdr(input logic [15:0] len, input logic [7:0] u, f,
                          input logic [15:0] a, q);
      logic [7:0] e[12];
      e = '{tid[15:8], tid[7:0], 8'h00, 8'h00, len[15:8], len[7:0], u, f,
            a[15:8], a[7:0], q[15:8], q[7:0]};
      `CHK(mbtcp_server_model_i.frame.size(), 6 + int'(len))
      for (int i = 0; i < 12; i++) `CHK(mbtcp_server_model_i.frame[i], e[i])
      `CHK({rsp_ok, rsp_err}, 2'b10)
      tid++;
   endtask
   task automatic t_link;
      req_valid = 1'b1;
      cycle(5);
      `CHK({req_ready, tx_valid}, 2'b00)
      req_valid = 1'b0;
      link_up = 1'b1;
      cycle(1);
      `CHK(req_ready, 1'b1)
   endtask
   task automatic t_basic;
      logic [7:0] fc[5] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h05};
      logic [15:0] qv[5] = '{16'h0008, 16'h0004, 16'h0002, 16'hff00, 16'h0000};
      for (int i = 0; i < 5; i++) begin
         logic [7:0] u = (i == 0) ? 8'h00 : 8'hf7;
         do_req(fc[i], u, 16'h0003, qv[i]);
         chk_hdr(16'h0006, u, fc[i], 16'h0003, qv[i]);
         if (i == 3) `CHK(mbtcp_server_model_i.relays[3], 1'b1)
      end
      `CHK(mbtcp_server_model_i.relays[3], 1'b0)
   endtask
   task automatic t_write;
      int n;
      for (n = 0; n < 20 && wdata_ready === 1'b1; n++) begin
         wdata_valid = 1'b1;
         wdata = {~8'(n * 17), 8'(n * 17)};
         cycle(1);
      end
      wdata_valid = 1'b0;
      `CHK(n, 16)
      stall = 1'b1;
      do_req(8'h10, 8'h01, 16'h0020, 16'h0010);
      chk_hdr(16'h0027, 8'h01, 8'h10, 16'h0020, 16'h0010);
      `CHK(mbtcp_server_model_i.frame[12], 8'h20)
      for (int i = 0; i < 16; i++)
         `CHK(mbtcp_server_model_i.regs[32 + i], {~8'(i * 17), 8'(i * 17)})
      `CHK(wdata_ready, 1'b1)
      stall = 1'b0;
   endtask
   task automatic t_error;
      bad_tid = 1'b1;
      do_req(8'h03, 8'h01, 16'h0000, 16'h0001);
      `CHK({rsp_ok, rsp_err}, 2'b01)
      bad_tid = 1'b0;
      mute = 1'b1;
      do_req(8'h01, 8'h01, 16'h0000, 16'h0001);
      `CHK({rsp_ok, rsp_err}, 2'b01)
      mute = 1'b0;
   endtask
   task automatic t_refuse;
      logic [7:0] fc[4] = '{8'h03, 8'h00, 8'h04, 8'h05};
      logic [7:0] un[4] = '{8'hf8, 8'h01, 8'h01, 8'h01};
      for (int i = 0; i < 4; i++) begin
         do_req(fc[i], un[i], 16'h0000, 16'h1234);
         `CHK({bad_req, tx_valid}, 2'b10)
      end
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      #1 reset_n = 1'b1;
      t_link;
      t_basic;
      t_write;
      t_error;
      t_refuse;
      finish_test;
   end
   // Whole run needs well under 5000 cycles
   initial begin
      #500000;
      err_count++;
      finish_test;
   end
endmodule
